// *** src/iss_top.sv ***
// Inch, take-up-slack and creep selection of the ramp generator's speed demand.
// Assumes commands from the sequencer_block are synchronous; AXI4-Lite master holds payloads.
// Operation
// - Run off, inch on: ramp input becomes inch setpoint A or B by selector
// - While inching, inch ramp time replaces main_accel_time and main_decel_time
// - While inching, ramp S-curve proportion forced to zero percent
// - Inching accel and decel both use the one inch ramp time
// - Inch ramp time accepted from 0.1 s up to 600.0 s
// - Run and inch on, selector false: setpoint plus slack A, default ramps
// - Run on, inch off, selector true: setpoint plus slack B, default ramps
// - Run and inch on, selector true: creep setpoint, default ramps
// - Only ramp input changes; direct setpoints still summed outside
// - Inch, slack and creep setpoints span -100.00 to +100.00 percent
// - Run only with selector false, or both commands off: pass setpoint through
// - Resulting demand is output to the ramp generator input
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`default_nettype none
module iss_top #(
    parameter int SP_WIDTH = 16,
    parameter int RT_WIDTH = 13
) (
    input wire logic aclk,
    input wire logic aresetn,
    // Sequencer and setpoint inputs
    input wire logic run_command_input,
    input wire logic inch_command_input,
    input wire logic selector_input,
    input wire logic signed [SP_WIDTH-1:0] ramp_setpoint,
    // Outputs to the ramp generator
    output logic signed [SP_WIDTH-1:0] ramp_input_out,
    output logic inch_ramp_override,
    output logic [RT_WIDTH-1:0] inch_ramp_time,
    output logic s_curve_zero,
    output logic [2:0] selection_state_code,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Widths are tied to the package encodings and to the 16-bit write lane
    if (SP_WIDTH != iss_pkg::SP_W) begin : g_bad_sp_width
        $error("iss_top: setpoint width must match the package");
    end
    if (RT_WIDTH != iss_pkg::RT_W) begin : g_bad_rt_width
        $error("iss_top: ramp time width must match the package");
    end
    if (SP_WIDTH != 16) begin : g_bad_sp_lane
        $error("iss_top: setpoints must fill the 16-bit write lane");
    end
    if (RT_WIDTH >= 16) begin : g_bad_rt_lane
        $error("iss_top: ramp time must be narrower than the write lane");
    end

    // Setting registers
    logic signed [SP_WIDTH-1:0] inch_sp_a, inch_sp_b, slack_sp_a, slack_sp_b, creep_sp;
    logic [RT_WIDTH-1:0] inch_rt;
    logic sel_soft, sel_from_reg;

    // Write channel capture
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [15:0] wr_half;
    logic [15:0] sp_clamped;
    logic [RT_WIDTH-1:0] rt_clamped;

    // Accept address and data in either order, each held until the write is done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // Ready is high while the channel's holding slot is free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !(aw_held || (s_axi_awvalid && s_axi_awready)) || do_write;
            s_axi_wready <= !(w_held || (s_axi_wvalid && s_axi_wready)) || do_write;
        end
    end

    // Byte lanes merge into the low half-word of the old value
    always_comb begin
        wr_half = 16'h0000;
        case (aw_addr)
            iss_pkg::OFS_INCH_A: wr_half = inch_sp_a;
            iss_pkg::OFS_INCH_B: wr_half = inch_sp_b;
            iss_pkg::OFS_SLACK_A: wr_half = slack_sp_a;
            iss_pkg::OFS_SLACK_B: wr_half = slack_sp_b;
            iss_pkg::OFS_CREEP: wr_half = creep_sp;
            iss_pkg::OFS_INCH_RT: wr_half = {3'h0, inch_rt};
            default: wr_half = 16'h0000;
        endcase
        if (w_strb[0]) begin
            wr_half[7:0] = w_data[7:0];
        end
        if (w_strb[1]) begin
            wr_half[15:8] = w_data[15:8];
        end
    end

    iss_sp_clamp #(.W(16), .SIGNED(1'b1), .MIN(iss_pkg::SP_MIN), .MAX(iss_pkg::SP_MAX)) u_sp_clamp (
        .din(wr_half),
        .dout(sp_clamped)
    );

    iss_sp_clamp #(.W(RT_WIDTH), .SIGNED(1'b0), .MIN(iss_pkg::RT_MIN), .MAX(iss_pkg::RT_MAX)) u_rt_clamp (
        .din((|wr_half[15:RT_WIDTH]) ? iss_pkg::RT_MAX : wr_half[RT_WIDTH-1:0]),
        .dout(rt_clamped)
    );

    // Setting registers updated by writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inch_sp_a <= iss_pkg::SP_RST;
            inch_sp_b <= iss_pkg::SP_RST;
            slack_sp_a <= iss_pkg::SP_RST;
            slack_sp_b <= iss_pkg::SP_RST;
            creep_sp <= iss_pkg::SP_RST;
            inch_rt <= iss_pkg::RT_RST;
            sel_soft <= 1'b0;
            sel_from_reg <= 1'b0;
        end else if (do_write) begin
            case (aw_addr)
                iss_pkg::OFS_INCH_A: inch_sp_a <= sp_clamped;
                iss_pkg::OFS_INCH_B: inch_sp_b <= sp_clamped;
                iss_pkg::OFS_SLACK_A: slack_sp_a <= sp_clamped;
                iss_pkg::OFS_SLACK_B: slack_sp_b <= sp_clamped;
                iss_pkg::OFS_CREEP: creep_sp <= sp_clamped;
                iss_pkg::OFS_INCH_RT: inch_rt <= rt_clamped;
                iss_pkg::OFS_CTRL: begin
                    if (w_strb[0]) begin
                        sel_soft <= w_data[iss_pkg::CTRL_SEL_BIT];
                        sel_from_reg <= w_data[iss_pkg::CTRL_SRC_BIT];
                    end
                end
                default: ;
            endcase
        end
    end

    // Write response; unmapped or read-only offsets answer with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= iss_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr <= iss_pkg::OFS_CTRL && aw_addr[1:0] == 2'h0) ?
                           iss_pkg::RESP_OKAY : iss_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Selection of the behaviour
    logic sel_level;
    iss_pkg::iss_sel_t next_sel;
    logic signed [SP_WIDTH-1:0] sum_slack_a, sum_slack_b;
    logic signed [SP_WIDTH-1:0] next_ramp_input;
    logic inching;

    // selector from pin unless software takes it
    assign sel_level = sel_from_reg ? sel_soft : selector_input;

    // Inching is run off with inch on, whichever selector
    assign inching = (next_sel == iss_pkg::SEL_INCH_A) || (next_sel == iss_pkg::SEL_INCH_B);

    iss_sat_add #(.W(SP_WIDTH)) u_add_a (
        .a(ramp_setpoint),
        .b(slack_sp_a),
        .sum(sum_slack_a)
    );

    iss_sat_add #(.W(SP_WIDTH)) u_add_b (
        .a(ramp_setpoint),
        .b(slack_sp_b),
        .sum(sum_slack_b)
    );

    // both commands sampled together; state code
    always_comb begin
        case ({run_command_input, inch_command_input, sel_level})
            3'b000: next_sel = iss_pkg::SEL_STOP_F;
            3'b001: next_sel = iss_pkg::SEL_STOP_T;
            3'b010: next_sel = iss_pkg::SEL_INCH_A;
            3'b011: next_sel = iss_pkg::SEL_INCH_B;
            3'b100: next_sel = iss_pkg::SEL_RUN;
            3'b110: next_sel = iss_pkg::SEL_SLACK_A;
            3'b101: next_sel = iss_pkg::SEL_SLACK_B;
            3'b111: next_sel = iss_pkg::SEL_CREEP;
            default: next_sel = iss_pkg::SEL_STOP_F;
        endcase
    end

    // Ramp input chosen from the selection
    always_comb begin
        case (next_sel)
            iss_pkg::SEL_INCH_A: next_ramp_input = inch_sp_a;
            iss_pkg::SEL_INCH_B: next_ramp_input = inch_sp_b;
            iss_pkg::SEL_SLACK_A: next_ramp_input = sum_slack_a;
            iss_pkg::SEL_SLACK_B: next_ramp_input = sum_slack_b;
            iss_pkg::SEL_CREEP: next_ramp_input = creep_sp;
            default: next_ramp_input = ramp_setpoint;
        endcase
    end

    // registered demand to ramp generator; direct setpoints untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ramp_input_out <= iss_pkg::SP_RST;
        end else begin
            ramp_input_out <= next_ramp_input;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            selection_state_code <= 3'h0;
        end else begin
            selection_state_code <= next_sel;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inch_ramp_override <= 1'b0;
        end else begin
            inch_ramp_override <= inching;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_curve_zero <= 1'b0;
        end else begin
            s_curve_zero <= inching;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inch_ramp_time <= iss_pkg::RT_RST;
        end else begin
            inch_ramp_time <= inch_rt;
        end
    end

    // Read channel
    logic [31:0] next_rdata;
    logic rd_ok;

    // Read data mux; unmapped offsets read zero with an error
    always_comb begin
        next_rdata = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            iss_pkg::OFS_INCH_A: next_rdata = {{16{inch_sp_a[15]}}, inch_sp_a};
            iss_pkg::OFS_INCH_B: next_rdata = {{16{inch_sp_b[15]}}, inch_sp_b};
            iss_pkg::OFS_SLACK_A: next_rdata = {{16{slack_sp_a[15]}}, slack_sp_a};
            iss_pkg::OFS_SLACK_B: next_rdata = {{16{slack_sp_b[15]}}, slack_sp_b};
            iss_pkg::OFS_CREEP: next_rdata = {{16{creep_sp[15]}}, creep_sp};
            iss_pkg::OFS_INCH_RT: next_rdata = {19'h0, inch_rt};
            iss_pkg::OFS_CTRL: next_rdata = {30'h0, sel_from_reg, sel_soft};
            iss_pkg::OFS_STATUS: next_rdata = {27'h0, inch_ramp_override, 1'b0, selection_state_code};
            iss_pkg::OFS_OUTPUT: next_rdata = {{16{ramp_input_out[15]}}, ramp_input_out};
            default: rd_ok = 1'b0;
        endcase
    end

    // One read at a time: address taken when no answer is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= iss_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= rd_ok ? iss_pkg::RESP_OKAY : iss_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** src/iss_pkg.sv ***
// Package for the inch/slack/creep setpoint selector.
// Assumes a 100 MHz control clock and an AXI4-Lite register bus of 32 bits.
`default_nettype none
package iss_pkg;
    // Speed setpoints: signed hundredths of a percent of full speed
    localparam int SP_W = 16;
    localparam logic signed [15:0] SP_MIN = -16'sd10000;
    localparam logic signed [15:0] SP_MAX = 16'sd10000;
    // Inch ramp time in tenths of a second
    localparam int RT_W = 13;
    localparam logic [12:0] RT_MIN = 13'h0001;
    localparam logic [12:0] RT_MAX = 13'h1770;
    localparam logic [12:0] RT_RST = 13'h0064;
    // Register byte offsets
    localparam logic [7:0] OFS_INCH_A = 8'h00;
    localparam logic [7:0] OFS_INCH_B = 8'h04;
    localparam logic [7:0] OFS_SLACK_A = 8'h08;
    localparam logic [7:0] OFS_SLACK_B = 8'h0c;
    localparam logic [7:0] OFS_CREEP = 8'h10;
    localparam logic [7:0] OFS_INCH_RT = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_OUTPUT = 8'h20;
    // Control and status field positions
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int STAT_CODE_LSB = 0;
    localparam int STAT_INCH_BIT = 4;
    // Reset values of setpoints
    localparam logic signed [15:0] SP_RST = 16'sh0000;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Selection state code
    typedef enum logic [2:0] {
        SEL_STOP_F, SEL_STOP_T, SEL_INCH_A, SEL_INCH_B,
        SEL_RUN, SEL_SLACK_A, SEL_SLACK_B, SEL_CREEP
    } iss_sel_t;
endpackage
`default_nettype wire

// *** src/iss_sat_add.sv ***
// Saturating signed adder for speed demands.
// Assumes operands in range; clamps result to plus/minus full speed.
`default_nettype none
module iss_sat_add #(
    parameter int W = 16
) (
    input wire logic signed [W-1:0] a,
    input wire logic signed [W-1:0] b,
    output logic signed [W-1:0] sum
);
    logic signed [W:0] wide;
    // Refuse widths that cannot hold full speed
    if (W < 15) begin : g_bad_width
        $error("iss_sat_add: width too small for full-speed range");
    end
    // Add at one extra bit, then clamp to full speed
    always_comb begin
        wide = $signed({a[W-1], a}) + $signed({b[W-1], b});
        if (wide > $signed({1'b0, W'(iss_pkg::SP_MAX)})) begin
            sum = W'(iss_pkg::SP_MAX);
        end else if (wide < $signed({1'b1, W'(iss_pkg::SP_MIN)})) begin
            sum = W'(iss_pkg::SP_MIN);
        end else begin
            sum = wide[W-1:0];
        end
    end
endmodule
`default_nettype wire

// *** src/iss_sp_clamp.sv ***
// Clamp of a value written by software into an allowed range.
// Assumes min is not above max; purely combinational.
`default_nettype none
module iss_sp_clamp #(
    parameter int W = 16,
    parameter bit SIGNED = 1'b1,
    parameter logic [W-1:0] MIN = '0,
    parameter logic [W-1:0] MAX = '0
) (
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // Refuse widths too narrow to hold a range
    if (W < 2) begin : g_bad_width
        $error("iss_sp_clamp: width must be at least two");
    end
    // Compare as signed or unsigned as chosen
    always_comb begin
        if (SIGNED ? ($signed(din) < $signed(MIN)) : (din < MIN)) begin
            dout = MIN;
        end else if (SIGNED ? ($signed(din) > $signed(MAX)) : (din > MAX)) begin
            dout = MAX;
        end else begin
            dout = din;
        end
    end
endmodule
`default_nettype wire

// *** test/iss_top_asserts.sv ***
// Port-level assertions for the setpoint selector.
// Assumes one clock domain with a synchronous active-low reset.
`default_nettype none
module iss_chk #(
    parameter int SP_WIDTH = 16,
    parameter int RT_WIDTH = 13
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run_command_input,
    input wire logic inch_command_input,
    input wire logic selector_input,
    input wire logic signed [SP_WIDTH-1:0] ramp_setpoint,
    input wire logic signed [SP_WIDTH-1:0] ramp_input_out,
    input wire logic inch_ramp_override,
    input wire logic [RT_WIDTH-1:0] inch_ramp_time,
    input wire logic s_curve_zero,
    input wire logic [2:0] selection_state_code,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Commands packed as run, inch, selector
    logic [2:0] cmd;
    assign cmd = {run_command_input, inch_command_input, selector_input};
    // Code follows the command word except that slack A and B swap places
    function automatic logic [2:0] code_of(input logic [2:0] c);
        code_of = (c == 3'h5) ? 3'h6 : (c == 3'h6) ? 3'h5 : c;
    endfunction
    sequence s_live;
        $past(aresetn);
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_code_map: assert property (s_live |-> selection_state_code == code_of($past(cmd)))
        else $error("state code does not follow commands");
    chk_inch_ovr: assert property (s_live |-> inch_ramp_override == ($past(cmd[2:1]) == 2'b01))
        else $error("ramp override does not follow inching");
    chk_scurve_zero: assert property (s_live |-> s_curve_zero == ($past(cmd[2:1]) == 2'b01))
        else $error("s-curve zero does not follow inching");
    chk_rt_range: assert property (inch_ramp_time >= 13'h0001 && inch_ramp_time <= 13'h1770)
        else $error("inch ramp time out of range");
    chk_pass_thru: assert property (s_live ##0 $past(cmd) inside {3'h0, 3'h1, 3'h4}
        |-> ramp_input_out == $past(ramp_setpoint))
        else $error("setpoint not passed through");
    chk_out_range: assert property (ramp_input_out >= -16'sd10000 && ramp_input_out <= 16'sd10000)
        else $error("demand beyond full speed");
    chk_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
endmodule
bind iss_top iss_chk #(.SP_WIDTH(SP_WIDTH), .RT_WIDTH(RT_WIDTH)) iss_chk_i (.aclk, .aresetn, .run_command_input,
    .inch_command_input, .selector_input, .ramp_setpoint, .ramp_input_out, .inch_ramp_override, .inch_ramp_time,
    .s_curve_zero, .selection_state_code, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// *** test/iss_seq_model.sv ***
// Sequencer model that drives run, inch and selector levels.
// Assumes requests from the bench arrive just after a rising edge.
`default_nettype none
module iss_seq_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req_run,
    input wire logic req_inch,
    input wire logic req_sel,
    output logic run_cmd,
    output logic inch_cmd,
    output logic sel_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {run_cmd, inch_cmd, sel_lvl} <= 3'h0;
        end else begin
            {run_cmd, inch_cmd, sel_lvl} <= {req_run, req_inch, req_sel};
        end
    end
endmodule
`default_nettype wire

// *** test/tb_inch_slack_setpoint_select.sv ***
// Self-checking bench for the setpoint selector.
// Assumes the sequencer model in front and AXI4-Lite register access.
`default_nettype none
module tb_inch_slack_setpoint_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic req_run = 1'b0, req_inch = 1'b0, req_sel = 1'b0;
    logic run_c, inch_c, sel_c, ovr, scz, awready, wready, bvalid, arready, rvalid;
    logic signed [15:0] sp = 16'sh0000;
    logic signed [15:0] dem;
    logic [12:0] rt;
    logic [2:0] code;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0] bresp, rresp;
    int err_total = 0, checked = 0, cycles = 0;
    always #5 aclk = ~aclk;
    iss_seq_model iss_seq_model_i (.aclk(aclk), .aresetn(aresetn), .req_run(req_run), .req_inch(req_inch),
        .req_sel(req_sel), .run_cmd(run_c), .inch_cmd(inch_c), .sel_lvl(sel_c));
    iss_top #(.SP_WIDTH(16), .RT_WIDTH(13)) iss_top_i (.aclk(aclk), .aresetn(aresetn), .run_command_input(run_c),
        .inch_command_input(inch_c), .selector_input(sel_c), .ramp_setpoint(sp), .ramp_input_out(dem),
        .inch_ramp_override(ovr), .inch_ramp_time(rt), .s_curve_zero(scz), .selection_state_code(code),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles > 20000) begin
            err_total++;
            end_of_test();
        end
    end
    // Write; response ready is raised one cycle after the answer shows
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_go, w_go, b_go, bv;
        logic [1:0] r;
        b_go = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!b_go) begin
            #1;
            aw_go = awvalid && awready;
            w_go = wvalid && wready;
            b_go = bvalid && bready;
            bv = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
            bready <= bv && !b_go;
        end
        chk(32'(r), 32'(er));
    endtask
    // Read and compare data and response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_go, r_go, rv;
        logic [31:0] d;
        logic [1:0] r;
        r_go = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        while (!r_go) begin
            #1;
            ar_go = arvalid && arready;
            r_go = rvalid && rready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_go) arvalid <= 1'b0;
            rready <= rv && !r_go;
        end
        chk(d, ed);
        chk(32'(r), 32'(er));
    endtask
    // Requests commands; outputs settle two edges later
    task automatic apply(input logic [2:0] c, input logic signed [15:0] s);
        @(posedge aclk);
        // run and inch rise together from stop
        if (c[2:1] == 2'b11) begin
            {req_run, req_inch, req_sel} <= 3'h0;
            @(posedge aclk);
        end
        {req_run, req_inch, req_sel} <= c;
        sp <= s;
        repeat (2) @(posedge aclk);
        #1;
    endtask
    task automatic t_reset_vals;
        rd_chk(iss_pkg::OFS_INCH_A, 32'h0, iss_pkg::RESP_OKAY);
        rd_chk(iss_pkg::OFS_INCH_RT, 32'h64, iss_pkg::RESP_OKAY);
        chk(32'(rt), 32'h64);
        rd_chk(8'h40, 32'h0, iss_pkg::RESP_SLVERR);
        axi_wr(iss_pkg::OFS_STATUS, 32'h7, iss_pkg::RESP_SLVERR);
        axi_wr(iss_pkg::OFS_CTRL, 32'h1, iss_pkg::RESP_OKAY);
        rd_chk(iss_pkg::OFS_CTRL, 32'h1, iss_pkg::RESP_OKAY);
    endtask
    task automatic t_clamp;
        axi_wr(iss_pkg::OFS_INCH_RT, 32'h0, iss_pkg::RESP_OKAY);
        rd_chk(iss_pkg::OFS_INCH_RT, 32'h1, iss_pkg::RESP_OKAY);
        chk(32'(rt), 32'h1);
        axi_wr(iss_pkg::OFS_INCH_RT, 32'h1771, iss_pkg::RESP_OKAY);
        rd_chk(iss_pkg::OFS_INCH_RT, 32'h1770, iss_pkg::RESP_OKAY);
        axi_wr(iss_pkg::OFS_CREEP, 32'h4e21, iss_pkg::RESP_OKAY);
        rd_chk(iss_pkg::OFS_CREEP, 32'h2710, iss_pkg::RESP_OKAY);
        axi_wr(iss_pkg::OFS_CREEP, 32'hffffb1df, iss_pkg::RESP_OKAY);
        rd_chk(iss_pkg::OFS_CREEP, 32'hffffd8f0, iss_pkg::RESP_OKAY);
    endtask
    // Every command combination against the selection table
    task automatic t_modes;
        int e;
        logic [31:0] ce;
        axi_wr(iss_pkg::OFS_INCH_A, 32'h3e8, iss_pkg::RESP_OKAY);
        axi_wr(iss_pkg::OFS_INCH_B, 32'hfffff830, iss_pkg::RESP_OKAY);
        axi_wr(iss_pkg::OFS_SLACK_A, 32'h1f4, iss_pkg::RESP_OKAY);
        axi_wr(iss_pkg::OFS_SLACK_B, 32'hfffffd44, iss_pkg::RESP_OKAY);
        axi_wr(iss_pkg::OFS_CREEP, 32'h12c, iss_pkg::RESP_OKAY);
        axi_wr(iss_pkg::OFS_INCH_RT, 32'h19, iss_pkg::RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            apply(3'(i), 16'sd4000);
            case (i)
                2: e = 1000;
                3: e = -2000;
                5: e = 4000 - 700;
                6: e = 4000 + 500;
                7: e = 300;
                default: e = 4000;
            endcase
            ce = (i == 5) ? 32'h6 : (i == 6) ? 32'h5 : 32'(i);
            chk(32'(dem), 32'(e));
            chk(32'(code), ce);
            chk(32'(ovr), 32'(i == 2 || i == 3));
            chk(32'(scz), 32'(i == 2 || i == 3));
            chk(32'(rt), 32'h19);
            rd_chk(iss_pkg::OFS_OUTPUT, 32'(e), iss_pkg::RESP_OKAY);
            rd_chk(iss_pkg::OFS_STATUS, ((i == 2 || i == 3) ? 32'h10 : 32'h0) | ce, iss_pkg::RESP_OKAY);
        end
    endtask
    // Slack sums saturate at full speed
    task automatic t_sat;
        apply(3'h6, 16'sd9800);
        chk(32'(dem), 32'h2710);
        apply(3'h5, -16'sd9900);
        chk(32'(dem), 32'hffffd8f0);
    endtask
    // Reset in mid-run returns outputs and settings to their reset values
    task automatic t_reset_mid;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        chk(32'(dem), 32'h0);
        chk(32'(rt), 32'h64);
        @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(iss_pkg::OFS_CREEP, 32'h0, iss_pkg::RESP_OKAY);
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_vals();
        t_clamp();
        t_modes();
        t_sat();
        t_reset_mid();
        end_of_test();
    end
endmodule
`default_nettype wire
